//--- hw/rtca_alarm_ctrl.sv
// Alarm control word of the real-time clock, reached as an AXI4-Lite slave.
// Assumes the time counters run on aclk and send one-cycle strobes, and
// that aresetn is the power-on reset of the block.
module rtca_alarm_ctrl #(
    parameter int ADDR_W = 4,
    parameter int PRESC_W = 16
) (
    // Clock, power-on reset, clock enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write address
    input wire logic awvalid,
    output logic awready,
    input wire logic [ADDR_W-1:0] awaddr,
    input wire logic [2:0] awprot,
    // AXI4-Lite write data
    input wire logic wvalid,
    output logic wready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    // AXI4-Lite write response
    output logic bvalid,
    input wire logic bready,
    output logic [1:0] bresp,
    // AXI4-Lite read address
    input wire logic arvalid,
    output logic arready,
    input wire logic [ADDR_W-1:0] araddr,
    input wire logic [2:0] arprot,
    // AXI4-Lite read data
    output logic rvalid,
    input wire logic rready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    // Time counters
    input wire rtca_pkg::rtca_time_t time_in,
    input wire logic [PRESC_W-1:0] prescaler_remaining,
    // Alarm outputs
    output logic alarm_pulse,
    output logic alarm_event
);

    // Parameters the logic cannot serve
    generate
        if (ADDR_W < 3 || ADDR_W > 32) begin : g_bad_addr
            $error("ADDR_W must lie between 3 and 32");
        end
        if (PRESC_W < 6) begin : g_bad_presc
            $error("PRESC_W too narrow for the sync window");
        end
    endgenerate

    localparam logic [PRESC_W-1:0] SYNC_WINDOW = PRESC_W'(rtca_pkg::SYNC_WINDOW_CLKS);

    rtca_pkg::rtca_ctrl_t ctrl;
    logic read_unsafe;
    logic aw_got;
    logic w_got;
    logic [ADDR_W-1:0] awaddr_q;
    logic [31:0] wdata_q;
    logic [3:0] wstrb_q;
    logic wr_commit;
    logic wr_hit;
    logic evt;

    // Word address decode, shared by both channels
    function automatic logic addr_hit(input logic [ADDR_W-1:0] a);
        addr_hit = (a[ADDR_W-1:2] == (ADDR_W-2)'(rtca_pkg::ALARM_CONTROL_OFFSET >> 2));
    endfunction

    // Interval decode; reserved codes never fire
    function automatic logic interval_hit(input logic [3:0] iv, input rtca_pkg::rtca_time_t t);
        interval_hit = 1'b0;
        if (iv == rtca_pkg::IV_HALF_SECOND) begin
            interval_hit = 1'b1;
        end else if (iv == rtca_pkg::IV_YEAR) begin
            interval_hit = t.match[iv] && (!t.alarm_on_feb29 || t.leap_year);
        end else if (iv < 4'(rtca_pkg::IV_CODES)) begin
            interval_hit = t.match[iv];
        end
    endfunction

    // Armed alarm event on a half-second tick
    assign evt = ce && ctrl.enable && time_in.half_tick && interval_hit(ctrl.interval, time_in);
    assign wr_commit = ce && aw_got && w_got && !bvalid;
    assign wr_hit = addr_hit(awaddr_q);

    // Write address channel; held until the response is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b0;
            aw_got <= 1'b0;
            awaddr_q <= '0;
        end else if (ce) begin
            if (awvalid && awready) begin
                awready <= 1'b0;
                aw_got <= 1'b1;
                awaddr_q <= awaddr;
            end else if (wr_commit) begin
                aw_got <= 1'b0;
            end else if (!aw_got && !bvalid && !(bvalid && bready)) begin
                awready <= 1'b1;
            end
        end
    end

    // Write data channel, taken independently of the address
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            wready <= 1'b0;
            w_got <= 1'b0;
            wdata_q <= '0;
            wstrb_q <= '0;
        end else if (ce) begin
            if (wvalid && wready) begin
                wready <= 1'b0;
                w_got <= 1'b1;
                wdata_q <= wdata;
                wstrb_q <= wstrb;
            end else if (wr_commit) begin
                w_got <= 1'b0;
            end else if (!w_got && !bvalid) begin
                wready <= 1'b1;
            end
        end
    end

    // Write response once both halves have landed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            bvalid <= 1'b0;
            bresp <= rtca_pkg::RESP_OKAY;
        end else if (ce) begin
            if (wr_commit) begin
                bvalid <= 1'b1;
                bresp <= wr_hit ? rtca_pkg::RESP_OKAY : rtca_pkg::RESP_SLVERR;
            end else if (bvalid && bready) begin
                bvalid <= 1'b0;
            end
        end
    end

    // Arm bit and settings; the hardware clear beats a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl.enable <= 1'b0;
            ctrl.wrap <= 1'b0;
            ctrl.interval <= rtca_pkg::INTERVAL_RESET;
        end else if (ce) begin
            if (wr_commit && wr_hit && wstrb_q[1]) begin
                ctrl.enable <= wdata_q[rtca_pkg::ENABLE_BIT];
                ctrl.wrap <= wdata_q[rtca_pkg::WRAP_BIT];
                ctrl.interval <= wdata_q[rtca_pkg::INTERVAL_LSB +: 4];
            end
            if (evt && ctrl.count == 8'h00 && !ctrl.wrap) begin
                ctrl.enable <= 1'b0;
            end
        end
    end

    // Repeat count; the event wins over a same-cycle write
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            ctrl.count <= rtca_pkg::COUNT_RESET;
        end else if (ce) begin
            if (evt) begin
                if (ctrl.count != 8'h00) begin
                    ctrl.count <= ctrl.count - 8'h01;
                end else if (ctrl.wrap) begin
                    ctrl.count <= rtca_pkg::COUNT_WRAP;
                end else begin
                    ctrl.count <= ctrl.count;
                end
            end else if (wr_commit && wr_hit && wstrb_q[0]) begin
                ctrl.count <= wdata_q[rtca_pkg::COUNT_LSB +: 8];
            end
        end
    end

    // Pulse level; initial value only loads while disarmed
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_pulse <= 1'b0;
        end else if (ce) begin
            if (evt) begin
                alarm_pulse <= !alarm_pulse;
            end else if (wr_commit && wr_hit && wstrb_q[1] && !ctrl.enable) begin
                alarm_pulse <= wdata_q[rtca_pkg::PULSE_BIT];
            end
        end
    end

    // Event strobe for the interrupt logic
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            alarm_event <= 1'b0;
        end else if (ce) begin
            alarm_event <= evt;
        end
    end

    // Read-unsafe flag; registered so a read sees a stable bit
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            read_unsafe <= 1'b0;
        end else if (ce) begin
            read_unsafe <= (prescaler_remaining <= SYNC_WINDOW);
        end
    end

    // Read channel; one read in flight, answered the next cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b0;
            rvalid <= 1'b0;
            rdata <= '0;
            rresp <= rtca_pkg::RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                if (addr_hit(araddr)) begin
                    // Pulse bit always mirrors the live level
                    rdata <= {16'h0000, ctrl.enable, ctrl.wrap, alarm_pulse, read_unsafe,
                              ctrl.interval, ctrl.count};
                    rresp <= rtca_pkg::RESP_OKAY;
                end else begin
                    rdata <= '0;
                    rresp <= rtca_pkg::RESP_SLVERR;
                end
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
            end else if (!rvalid) begin
                arready <= 1'b1;
            end
        end
    end

    // Checks on the alarm behaviour; all of them live in the aclk domain
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);

    // Arm bit and repeat count
    a_arm_on_write: assert property (
        wr_commit && wr_hit && wstrb_q[1] && wdata_q[15] && !evt
        |=> ctrl.enable)
        else $error("arm write did not take");
    a_disarm_quiet: assert property (
        ce && !ctrl.enable
        |=> !alarm_event)
        else $error("event while disarmed");
    a_wrap_roll: assert property (
        evt && ctrl.count == 8'h00 && ctrl.wrap
        |=> ctrl.count == 8'hFF)
        else $error("repeat count did not wrap");
    a_halt_zero: assert property (
        evt && ctrl.count == 8'h00 && !ctrl.wrap
        |=> ctrl.count == 8'h00)
        else $error("repeat count left zero without wrap");
    a_auto_disarm: assert property (
        evt && ctrl.count == 8'h00 && !ctrl.wrap
        |=> !ctrl.enable && alarm_event)
        else $error("arm bit not cleared at last repeat");
    a_count_step: assert property (
        evt && ctrl.count != 8'h00
        |=> ctrl.count == $past(ctrl.count) - 8'h01 && alarm_pulse != $past(alarm_pulse))
        else $error("event did not step count and pulse");
    a_count_write: assert property (
        wr_commit && wr_hit && wstrb_q[0] && !evt
        |=> ctrl.count == $past(wdata_q[7:0]))
        else $error("repeat count write lost");

    // Pulse level, loaded while disarmed and toggled while armed
    a_pulse_load: assert property (
        wr_commit && wr_hit && wstrb_q[1] && !ctrl.enable && !evt
        |=> alarm_pulse == $past(wdata_q[13]))
        else $error("pulse initial value not loaded");
    a_pulse_locked: assert property (
        ce && ctrl.enable && !evt
        |=> $stable(alarm_pulse))
        else $error("pulse changed while armed without event");
    a_pulse_readback: assert property (
        ce && arvalid && arready && addr_hit(araddr)
        |=> rdata[13] == $past(alarm_pulse))
        else $error("read does not show pulse level");

    // Interval decode and event strobe
    a_reserved_quiet: assert property (
        ce && ctrl.interval > 4'h9
        |-> !evt)
        else $error("event on reserved interval code");
    a_half_fire: assert property (
        ce && ctrl.enable && time_in.half_tick && ctrl.interval == 4'h0
        |=> alarm_event)
        else $error("half-second alarm missed");

    // Read-unsafe flag on both sides of the window
    a_unsafe_set: assert property (
        ce && prescaler_remaining <= SYNC_WINDOW
        |=> read_unsafe)
        else $error("read-unsafe clear near rollover");
    a_unsafe_clear: assert property (
        ce && prescaler_remaining > SYNC_WINDOW
        |=> !read_unsafe)
        else $error("read-unsafe set far from rollover");

    // Bus answers
    a_aw_take: assert property (
        ce && awvalid && awready
        |=> !awready && aw_got)
        else $error("write address not held after take");
    a_r_answer: assert property (
        ce && arvalid && arready
        |=> rvalid && !arready)
        else $error("read not answered next cycle");
    a_wr_unmapped: assert property (
        wr_commit && !wr_hit
        |=> bvalid && bresp == rtca_pkg::RESP_SLVERR)
        else $error("unmapped write not refused");
    a_rd_unmapped: assert property (
        ce && arvalid && arready && !addr_hit(araddr)
        |=> rresp == rtca_pkg::RESP_SLVERR && rdata == 32'h0000_0000)
        else $error("unmapped read not refused");
    a_upper_zero: assert property (
        rvalid
        |-> rdata[31:16] == 16'h0000)
        else $error("upper bits not zero");

    // Clock enable low must freeze every flop, bus side included
    a_ce_freeze: assert property (
        !ce
        |=> $stable(ctrl) && $stable(alarm_pulse) && $stable(alarm_event) && $stable(read_unsafe))
        else $error("alarm state moved while clock enable low");
    a_ce_bus_freeze: assert property (
        !ce
        |=> $stable(awready) && $stable(wready) && $stable(bvalid) && $stable(arready) && $stable(rvalid))
        else $error("bus state moved while clock enable low");

    // Main scenarios
    c_wrap: cover property (evt && ctrl.count == 8'h00 && ctrl.wrap);
    c_disarm: cover property (evt && ctrl.count == 8'h00 && !ctrl.wrap);
    c_unsafe_read: cover property (rvalid && rdata[12]);
    c_write_done: cover property (bvalid && bready && bresp == 2'h0);
    c_ce_hold: cover property (!ce && time_in.half_tick && ctrl.enable);

endmodule // rtca_alarm_ctrl

//--- hw/rtca_pkg.sv
// Constants, field layout and carriers of the alarm control block.
// Assumes one clock, and time counters that deliver same-clock strobes.
// Overview of operation
// - Bit 15 of the alarm control word arms the alarm when one and disarms it when zero.
// - With wrap-around repeat on, the eight-bit repeat count rolls from 0x00 to 0xFF and keeps going.
// - With wrap-around repeat off, the repeat count stops once it holds 0x00.
// - While disarmed, bit 13 is writable and sets the starting level of the alarm pulse.
// - While armed, bit 13 ignores writes and reads back the present alarm pulse level.
// - The read-unsafe flag reads one near a half-second rollover, zero when more than 32 clocks away.
// - Interval codes 0000 to 0101 select half-second, second, ten seconds, minute, ten minutes and hour.
// - Codes 0110 to 1001 select daily, weekly, monthly, yearly; a yearly alarm on February 29 fires in leap years.
// - An alarm event with repeat count 00 and wrap-around off clears the arm bit.
// - Only the power-on reset clears the alarm control word; other resets leave it alone.
// - Bits 31 to 16 of the alarm control word always read zero.
package rtca_pkg;

    // Register map
    localparam logic [3:0] ALARM_CONTROL_OFFSET = 4'h0;

    // Field positions inside the alarm control word
    localparam int ENABLE_BIT = 15;
    localparam int WRAP_BIT = 14;
    localparam int PULSE_BIT = 13;
    localparam int UNSAFE_BIT = 12;
    localparam int INTERVAL_LSB = 8;
    localparam int COUNT_LSB = 0;

    // Values after power-on, and the repeat count reload on wrap
    localparam logic [7:0] COUNT_RESET = 8'h00;
    localparam logic [3:0] INTERVAL_RESET = 4'h0;
    localparam logic [7:0] COUNT_WRAP = 8'hFF;

    // Distance to rollover under which a read may tear, in clocks
    localparam int SYNC_WINDOW_CLKS = 32;

    // Interval select codes
    localparam logic [3:0] IV_HALF_SECOND = 4'h0;
    localparam logic [3:0] IV_YEAR = 4'h9;
    localparam int IV_CODES = 10;

    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Stored alarm control fields
    typedef struct packed {
        logic enable;
        logic wrap;
        logic [3:0] interval;
        logic [7:0] count;
    } rtca_ctrl_t;

    // Strobes from the time and date counters
    typedef struct packed {
        logic half_tick;
        logic [IV_CODES-1:0] match;
        logic alarm_on_feb29;
        logic leap_year;
    } rtca_time_t;

endpackage : rtca_pkg

//--- verification/tb_rtc_alarm_control.sv
// Self-checking bench for the alarm control word, AXI4-Lite side and alarm strobes.
// Assumes rtca_pkg is compiled first and aresetn acts as the power-on reset.
module tb_rtc_alarm_control;
    timeunit 1ns;
    timeprecision 1ps;

    logic aclk = 0, aresetn = 0, ce = 1, awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [3:0] awaddr = 0, araddr = 0, wstrb = 0;
    logic [31:0] wdata = 0, seed = 32'h0001_6354, d1, d2;
    logic [15:0] presc = 16'h03E8;
    rtca_pkg::rtca_time_t tin = '0;
    wire awready, wready, bvalid, arready, rvalid, alarm_pulse, alarm_event;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    // Expected state of the alarm word
    logic m_en = 0, m_wr = 0, m_pl = 0, m_us = 0;
    logic [3:0] m_iv = 0;
    logic [7:0] m_ct = 0;
    int err_total = 0, comparisons = 0;

    rtca_alarm_ctrl u_dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awvalid(awvalid), .awready(awready),
        .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
        .bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid), .arready(arready),
        .araddr(araddr), .arprot(3'h0), .rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
        .time_in(tin), .prescaler_remaining(presc), .alarm_pulse(alarm_pulse), .alarm_event(alarm_event));

    // Free-running 125 MHz clock
    initial begin
        forever #4 aclk = ~aclk;
    end

    function automatic logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] exp_rd();
        return {16'h0000, m_en, m_wr, m_pl, m_us, m_iv, m_ct};
    endfunction

    task automatic results();
        if (err_total == 0 && comparisons > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        comparisons++;
        if (g !== e) begin
            err_total++;
            $display("[FAIL] %0t got %h expected %h", $time, g, e);
        end
    endtask

    // A used-up wait bound ends the run as a mismatch
    task automatic tmo(input int n);
        if (n >= 50) begin
            err_total++;
            $display("[FAIL] %0t handshake timeout", $time);
            results();
        end
    endtask

    // Write; model follows, pulse level judged on the arm bit before the write
    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [3:0] s);
        int n;
        logic ad, dd;
        ad = 0;
        dd = 0;
        n = 0;
        @(posedge aclk);
        awvalid <= 1;
        wvalid <= 1;
        awaddr <= a;
        wdata <= d;
        wstrb <= s;
        bready <= 1;
        while (!(ad && dd) && n < 50) begin
            @(posedge aclk);
            n++;
            if (awvalid && awready) begin
                ad = 1;
                awvalid <= 0;
            end
            if (wvalid && wready) begin
                dd = 1;
                wvalid <= 0;
            end
        end
        do begin
            @(posedge aclk);
            n++;
        end while (!bvalid && n < 50);
        bready <= 0;
        tmo(n);
        chk(bresp, (a[3:2] == 2'b00) ? rtca_pkg::RESP_OKAY : rtca_pkg::RESP_SLVERR);
        if (a[3:2] == 2'b00) begin
            if (s[1]) begin
                if (!m_en) m_pl = d[13];
                m_en = d[15];
                m_wr = d[14];
                m_iv = d[11:8];
            end
            if (s[0]) m_ct = d[7:0];
        end
    endtask

    task automatic rd(input logic [3:0] a, output logic [31:0] d, output logic [1:0] r);
        int n;
        n = 0;
        @(posedge aclk);
        arvalid <= 1; araddr <= a; rready <= 1;
        while (n < 50) begin
            @(posedge aclk);
            n++;
            if (arvalid && arready) arvalid <= 0;
            if (rvalid) break;
        end
        d = rdata;
        r = rresp;
        rready <= 0;
        tmo(n);
    endtask

    task automatic rdc(input logic [3:0] a, input logic [31:0] e, input logic [1:0] er);
        logic [31:0] d;
        logic [1:0] r;
        rd(a, d, r);
        chk(d, e);
        chk(r, er);
    endtask

    // Half-second tick with match levels v[9:0], February 29 flag v[10], leap year v[11]
    task automatic tick(input logic [11:0] v);
        logic h;
        h = m_en && (m_iv == 0 || (m_iv <= 8 && v[m_iv]) || (m_iv == 9 && v[9] && (!v[10] || v[11])));
        @(posedge aclk);
        tin.half_tick <= 1;
        tin.match <= v[9:0];
        tin.alarm_on_feb29 <= v[10];
        tin.leap_year <= v[11];
        @(posedge aclk);
        tin.half_tick <= 0;
        @(negedge aclk);
        chk(alarm_event, h);
        if (h) begin
            m_pl = ~m_pl;
            if (m_ct != 0) m_ct--;
            else if (m_wr) m_ct = 8'hFF;
            else m_en = 0;
        end
        chk(alarm_pulse, m_pl);
    endtask

    task automatic reset_all();
        aresetn <= 0;
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        {m_en, m_wr, m_pl, m_us, m_iv, m_ct} = '0;
    endtask

    // Main sequence
    initial begin
        logic [31:0] r;
        reset_all();
        rdc(4'h0, 32'h0000_0000, rtca_pkg::RESP_OKAY);
        rdc(4'h4, 32'h0000_0000, rtca_pkg::RESP_SLVERR);
        wr(4'h8, 32'h0000_FFFF, 4'hF);
        wr(4'h0, 32'hFFFF_3000, 4'hF);
        chk(alarm_pulse, 1'b1);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        wr(4'h0, 32'h0000_8005, 4'h3);
        wr(4'h0, 32'h0000_A005, 4'h3);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        tick(12'h000);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        // Wrap from zero, then halt and disarm
        wr(4'h0, 32'h0000_C000, 4'h3);
        tick(12'h000);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        wr(4'h0, 32'h0000_8000, 4'h3);
        tick(12'h000);
        tick(12'h000);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        // Every legal interval code hit, plus a miss for codes 1 to 9
        for (int i = 0; i < 10; i++) begin
            wr(4'h0, 32'h0000_C005 | (i << 8), 4'h3);
            tick(12'(1 << i));
            tick(12'(~(1 << i)) & 12'h3FF);
        end
        // Yearly alarm on February 29 only in leap years
        wr(4'h0, 32'h0000_C905, 4'h3);
        tick(12'h600);
        tick(12'hE00);
        // Read-unsafe flag at both sides of the window
        @(posedge aclk);
        presc <= 16'h0020;
        m_us = 1;
        repeat (2) @(posedge aclk);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        // Two agreeing reads, each done in a few clocks
        rd(4'h0, d1, r[1:0]);
        rd(4'h0, d2, r[1:0]);
        chk(d1, d2);
        presc <= 16'h0021;
        m_us = 0;
        repeat (2) @(posedge aclk);
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        // Random traffic, written only while the flag is clear
        presc <= 16'h03E8;
        for (int k = 0; k < 30; k++) begin
            r = xs();
            r[11:8] = r[11:8] % 4'hA;
            r[7:2] = 6'h00;
            r[15] = r[15] | r[16];
            wr(4'h0, r, 4'(xs()));
            repeat (3) tick(12'(xs()));
            rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        end
        // Clock enable low swallows a half-second tick and freezes the word
        wr(4'h0, 32'h0000_8005, 4'h3);
        ce <= 0;
        tin.half_tick <= 1;
        @(posedge aclk);
        tin.half_tick <= 0;
        @(negedge aclk);
        chk(alarm_event, 1'b0);
        chk(alarm_pulse, m_pl);
        @(posedge aclk);
        ce <= 1;
        rdc(4'h0, exp_rd(), rtca_pkg::RESP_OKAY);
        // Second reset in mid-run clears the word
        wr(4'h0, 32'h0000_E0FF, 4'h3);
        reset_all();
        chk(alarm_pulse, 1'b0);
        rdc(4'h0, 32'h0000_0000, rtca_pkg::RESP_OKAY);
        results();
    end
endmodule // tb_rtc_alarm_control
